// File: design/write_buffer_pkg.sv
// constants shared by the write buffer scheduler and write-ack chain
package write_buffer_pkg;
  // ==========================================================
  // buffer geometry
  localparam int DEPTH    = 4;
  localparam int PTR_W    = 2;
  localparam int WB_ADR_W = 4;
  localparam int DIAG_W   = 7;
  localparam int ST_W     = 11;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [WB_ADR_W-1:0] REG_DIAG   = 4'h0;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'h4;

  // ==========================================================
  // diagnostic register fields
  localparam int DIAG_SINGLE    = 0;
  localparam int DIAG_DRAIN     = 1;
  localparam int DIAG_LWDIS     = 2;
  localparam int DIAG_BADPAR    = 3;
  localparam int DIAG_FORCE_EN  = 4;
  localparam int DIAG_FORCE_LSB = 5;
  localparam logic [DIAG_W-1:0] DIAG_RESET = 7'h00;

  // ==========================================================
  // status register fields
  localparam int ST_PEND_LSB = 0;
  localparam int ST_LW_LSB   = 4;
  localparam int ST_LW_VALID = 6;
  localparam int ST_BUSY     = 7;
  localparam int ST_DRAIN    = 8;
  localparam int ST_FULL     = 9;
  localparam int ST_CHAIN    = 10;

  // ==========================================================
  // location classes, ordered by scheduling preference
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_UNAL = 2'h1;
  localparam logic [1:0] CLS_AL32 = 2'h2;
  localparam logic [1:0] CLS_AL64 = 2'h3;

  // ==========================================================
  // valid and pending bit patterns
  localparam logic [3:0] VALID_RESET = 4'h0;
  localparam logic [3:0] VALID_ALL   = 4'hf;
  localparam logic [3:0] VALID_LO    = 4'h3;
  localparam logic [3:0] VALID_HI    = 4'hc;
  localparam logic [3:0] VALID_HALF  = 4'h1;
  localparam logic [1:0] PEND_RESET  = 2'h0;
  localparam logic [1:0] PEND_EVEN   = 2'h1;
  localparam logic [1:0] PEND_ODD    = 2'h2;
endpackage : write_buffer_pkg

// File: design/write_buffer_scheduler_ack.sv
// write buffer: scheduler, diagnostics and cpu write-ack chain
// How it works
// - decided location pointer is presented alongside the memory requests
// - 64-bit and odd flags accompany write request, zero otherwise
// - unaligned write stuck in location 0 triggers full drain
// - single-op diagnostic reports full once any location pends
// - drain-all diagnostic requests every pending op in priority order
// - last-written-disable lets last location compete, one acts as two
// - bad-parity diagnostic forces all address parity bits high
// - force bits pin the buffer pointer to a chosen value
// - write step latches address and data, sets busy and request
// - cache miss or fast 64-bit read latches address, busy, read request
// - buffer available only when chain done and timer idle
// - pre-ack starts chain, three one-beat delayed copies follow
// - latched address compared against all four stored addresses
// - first beat picks hit pointer on hit, else free pointer
// - first two beats hold input address latch closed, all four beats hold scheduler latch
// - second beat writes 16 or 32 data bits into data store
// - second beat stores address, sets pending, merges or sets valid
// - busy drops at third beat start
// - third beat updates the last-written latch
// - fourth beat ends the write abort window
// - normally the last-written location is never picked
// - two pending: request other location only if aligned
// - three or four: 64 then 32 then read, higher pointer wins
// - finished memory write clears both pending bits
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module write_buffer_scheduler_ack #(
  parameter int ADDR_W = 26
) (
  input  wire logic                                 clock,
  input  wire logic                                 clockEnable,
  input  wire logic                                 nrst,
  input  wire logic                                 cyc_i,
  input  wire logic                                 stb_i,
  input  wire logic                                 we_i,
  input  wire logic [write_buffer_pkg::WB_ADR_W-1:0] adr_i,
  input  wire logic [3:0]                           sel_i,
  input  wire logic [31:0]                          dat_i,
  output logic      [31:0]                          dat_o,
  output logic                                      ack_o,
  input  wire logic                                 stepCaptureEdge,
  input  wire logic                                 memWriteDest,
  input  wire logic                                 memWrite32Dest,
  input  wire logic                                 cacheMiss,
  input  wire logic                                 fastRead64Cmd,
  input  wire logic [ADDR_W-1:0]                    cpuAddr,
  input  wire logic [31:0]                          cpuData,
  output logic                                      memBusyN,
  output logic                                      cpuReadReq,
  input  wire logic                                 cpuReadDone,
  input  wire logic                                 mtIdle,
  output logic                                      mtWriteReq,
  output logic                                      mtReadReq,
  output logic                                      mtWrite64,
  output logic                                      mtWriteOdd,
  output logic      [write_buffer_pkg::PTR_W-1:0]   reqPointer,
  input  wire logic                                 mtWriteDone,
  input  wire logic                                 mtFillDone,
  input  wire logic [write_buffer_pkg::PTR_W-1:0]   mtDonePtr,
  output logic      [ADDR_W-3:0]                    memAddr,
  output logic      [(ADDR_W-2)/8-1:0]              memAddrParity,
  output logic      [63:0]                          memData,
  output logic                                      writeAbort,
  output logic                                      bufferFull
);
  import write_buffer_pkg::*;

  localparam int TAG_W = ADDR_W - 2;
  localparam int PAR_W = TAG_W / 8;

  if (ADDR_W < 10 || (TAG_W % 8) != 0) begin : g_check
    $error("ADDR_W must leave a tag that is a multiple of 8 bits");
  end

  // ==========================================================
  // state
  logic [ADDR_W-1:0] inAddr_reg;
  logic [31:0]       inData_reg;
  logic              is32_reg;
  logic              writeReq_reg;
  logic              readReq_reg;
  logic              busy_reg;
  logic              write_ack_chain_reg;
  logic              beat1_reg;
  logic              beat2_reg;
  logic              beat3_reg;
  logic              abort_reg;
  logic              hit_reg;
  logic [PTR_W-1:0]  wbPtr_reg;
  logic [PTR_W-1:0]  lastWritten_reg;
  logic              lwValid_reg;
  logic              autoDrain_reg;
  logic [DIAG_W-1:0] diag_reg;
  logic [TAG_W-1:0]  addrStore_reg [DEPTH];
  logic [63:0]       dataStore_reg [DEPTH];
  logic [3:0]        valid_reg     [DEPTH];
  logic [1:0]        pend_reg      [DEPTH];

  // ==========================================================
  // decode helpers
  function automatic logic [1:0] classify(input logic [3:0] v,
                                          input logic [1:0] p);
    logic [1:0] c;
    c = CLS_NONE;
    unique case (p)
      2'h0: c = CLS_NONE;
      2'h1: c = (v[1:0] == 2'h3) ? CLS_AL32 : CLS_UNAL;
      2'h2: c = (v[3:2] == 2'h3) ? CLS_AL32 : CLS_UNAL;
      2'h3: c = (v == VALID_ALL) ? CLS_AL64 : CLS_UNAL;
    endcase
    return c;
  endfunction : classify

  function automatic logic regSel(input logic [WB_ADR_W-1:0] a,
                                  input logic [WB_ADR_W-1:0] off);
    return a == off;
  endfunction : regSel

  function automatic logic [PAR_W-1:0] parityOf(input logic [TAG_W-1:0] a);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int b = 0; b < PAR_W; b++) begin
      p[b] = ^a[b*8 +: 8];
    end
    return p;
  endfunction : parityOf

  // ==========================================================
  // per-location compare and classification
  logic [DEPTH-1:0] pendAny;
  logic [DEPTH-1:0] hitVec;
  logic [DEPTH-1:0] consider;
  logic [1:0]       cls [DEPTH];
  logic             drainMode;
  logic             lwDis;

  assign drainMode = diag_reg[DIAG_DRAIN] || autoDrain_reg;
  assign lwDis     = diag_reg[DIAG_LWDIS];

  for (genvar i = 0; i < DEPTH; i++) begin : g_loc
    assign pendAny[i] = |pend_reg[i];
    assign cls[i]     = classify(valid_reg[i], pend_reg[i]);
    assign hitVec[i]  = (|valid_reg[i]) &&
                        (addrStore_reg[i] == inAddr_reg[ADDR_W-1:2]);
    assign consider[i] = pendAny[i] && (drainMode || lwDis ||
                         !lwValid_reg ||
                         (lastWritten_reg != PTR_W'(i)));
  end

  logic [PTR_W-1:0] hitPtr;
  logic [PTR_W-1:0] freePtr;
  logic [2:0]       nPend;
  logic             hitNow;

  // free pointer prefers the highest idle location
  always_comb begin
    hitPtr  = '0;
    freePtr = '0;
    nPend   = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (hitVec[i]) begin
        hitPtr = PTR_W'(i);
      end
      if (!pendAny[i]) begin
        freePtr = PTR_W'(i);
      end
      nPend = nPend + 3'(pendAny[i]);
    end
  end

  assign hitNow = |hitVec;

  // ==========================================================
  // scheduler decision
  logic [1:0]       bestCls;
  logic [PTR_W-1:0] bestPtr;
  logic             allowAligned;
  logic             allowUnal;
  logic             nextWr;
  logic             nextRd;

  always_comb begin
    bestCls = CLS_NONE;
    bestPtr = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (consider[i] && cls[i] != CLS_NONE && cls[i] >= bestCls) begin
        bestCls = cls[i];
        bestPtr = PTR_W'(i);
      end
    end
    allowAligned = drainMode || (nPend >= 3'd2) ||
                   (nPend == 3'd1 && lwDis);
    allowUnal    = drainMode || (nPend >= 3'd3);
    nextWr       = allowAligned && (bestCls >= CLS_AL32);
    nextRd       = allowUnal && (bestCls == CLS_UNAL);
  end

  // ==========================================================
  // availability and chain start
  logic chainActive;
  logic available;
  logic preWriteAckN;
  logic captureWrite;
  logic captureRead;
  logic inputLatchOpen;

  assign chainActive = write_ack_chain_reg || beat1_reg || beat2_reg || beat3_reg;
  assign available   = !chainActive && mtIdle;
  assign bufferFull  = diag_reg[DIAG_SINGLE] ? (|pendAny)
                                             : (&pendAny);
  assign preWriteAckN = !(writeReq_reg && available &&
                          (hitNow || !bufferFull));
  // busy keeps the pipeline off the latches
  assign captureWrite = stepCaptureEdge && !busy_reg &&
                        (memWriteDest || memWrite32Dest);
  assign captureRead  = stepCaptureEdge && !busy_reg && !captureWrite &&
                        (cacheMiss || fastRead64Cmd);
  assign inputLatchOpen = (captureWrite || captureRead) &&
                          !write_ack_chain_reg && !beat1_reg;
  assign memBusyN   = !busy_reg;
  assign cpuReadReq = readReq_reg && available;
  assign writeAbort = abort_reg;

  // ==========================================================
  // cpu request latches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inAddr_reg <= '0;
      inData_reg <= '0;
      is32_reg   <= 1'b0;
    end else if (clockEnable && inputLatchOpen) begin
      inAddr_reg <= cpuAddr;
      if (captureWrite) begin
        inData_reg <= cpuData;
        is32_reg   <= memWrite32Dest;
      end
    end
  end

  // request flags and busy; a new request beats a same-cycle clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      writeReq_reg <= 1'b0;
      readReq_reg  <= 1'b0;
      busy_reg     <= 1'b0;
    end else if (clockEnable) begin
      if (!preWriteAckN) begin
        writeReq_reg <= 1'b0;
      end
      if (cpuReadDone) begin
        readReq_reg <= 1'b0;
      end
      if (beat1_reg || cpuReadDone) begin
        busy_reg <= 1'b0;
      end
      if (captureWrite) begin
        writeReq_reg <= 1'b1;
      end
      if (captureRead) begin
        readReq_reg <= 1'b1;
      end
      if (captureWrite || captureRead) begin
        busy_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // write-ack chain
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      write_ack_chain_reg  <= 1'b0;
      beat1_reg <= 1'b0;
      beat2_reg <= 1'b0;
      beat3_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (clockEnable) begin
      write_ack_chain_reg  <= !preWriteAckN;
      beat1_reg <= write_ack_chain_reg;
      beat2_reg <= beat1_reg;
      beat3_reg <= beat2_reg;
      if (!preWriteAckN) begin
        abort_reg <= 1'b1;
      end else if (beat3_reg) begin
        abort_reg <= 1'b0;
      end
    end
  end

  // pointer choice taken as the chain starts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hit_reg   <= 1'b0;
      wbPtr_reg <= '0;
    end else if (clockEnable && !preWriteAckN) begin
      hit_reg <= hitNow;
      if (diag_reg[DIAG_FORCE_EN]) begin
        wbPtr_reg <= diag_reg[DIAG_FORCE_LSB +: PTR_W];
      end else begin
        wbPtr_reg <= hitNow ? hitPtr : freePtr;
      end
    end
  end

  // last-written latch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lastWritten_reg <= '0;
      lwValid_reg     <= 1'b0;
    end else if (clockEnable && beat2_reg) begin
      lastWritten_reg <= wbPtr_reg;
      lwValid_reg     <= 1'b1;
    end
  end

  // stuck unaligned location 0 forces a drain until empty
  logic stuckZero;

  assign stuckZero = pendAny[0] && (cls[0] == CLS_UNAL) && lwValid_reg &&
                     (lastWritten_reg != PTR_W'(0));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      autoDrain_reg <= 1'b0;
    end else if (clockEnable) begin
      if (stuckZero) begin
        autoDrain_reg <= 1'b1;
      end else if (nPend == 3'd0) begin
        autoDrain_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // buffer stores
  logic [3:0] writeMask;
  logic [1:0] pendMask;

  assign writeMask = is32_reg ? (inAddr_reg[1] ? VALID_HI : VALID_LO)
                              : (VALID_HALF << inAddr_reg[1:0]);
  assign pendMask  = inAddr_reg[1] ? PEND_ODD : PEND_EVEN;

  for (genvar i = 0; i < DEPTH; i++) begin : g_store
    logic setHere;
    logic clrHere;
    logic fillHere;
    logic [3:0] validBase;

    assign setHere   = beat1_reg && (wbPtr_reg == PTR_W'(i));
    assign clrHere   = mtWriteDone && (mtDonePtr == PTR_W'(i));
    assign fillHere  = mtFillDone && (mtDonePtr == PTR_W'(i));
    assign validBase = fillHere ? VALID_ALL : valid_reg[i];

    // setting pending wins over a same-cycle clear
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        valid_reg[i] <= VALID_RESET;
        pend_reg[i]  <= PEND_RESET;
      end else if (clockEnable) begin
        pend_reg[i] <= (clrHere ? PEND_RESET : pend_reg[i]) |
                       (setHere ? pendMask : PEND_RESET);
        if (setHere) begin
          valid_reg[i] <= (hit_reg ? validBase : VALID_RESET) |
                          writeMask;
        end else begin
          valid_reg[i] <= validBase;
        end
      end
    end

    always_ff @(posedge clock) begin
      if (clockEnable && setHere) begin
        addrStore_reg[i] <= inAddr_reg[ADDR_W-1:2];
        for (int h = 0; h < 4; h++) begin
          if (writeMask[h]) begin
            dataStore_reg[i][h*16 +: 16] <= (is32_reg && (h % 2 == 1)) ?
              inData_reg[31:16] : inData_reg[15:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // scheduler request latch toward the memory timer
  logic schedHold;

  assign schedHold = chainActive;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mtWriteReq <= 1'b0;
      mtReadReq  <= 1'b0;
      mtWrite64  <= 1'b0;
      mtWriteOdd <= 1'b0;
      reqPointer <= '0;
      memAddr    <= '0;
      memData    <= '0;
    end else if (clockEnable && !schedHold) begin
      mtWriteReq <= nextWr;
      mtReadReq  <= nextRd;
      mtWrite64  <= nextWr && (bestCls == CLS_AL64);
      mtWriteOdd <= nextWr && (bestCls == CLS_AL32) &&
                    (pend_reg[bestPtr] == PEND_ODD);
      reqPointer <= bestPtr;
      memAddr    <= addrStore_reg[bestPtr];
      memData    <= dataStore_reg[bestPtr];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memAddrParity <= '0;
    end else if (clockEnable) begin
      memAddrParity <= diag_reg[DIAG_BADPAR] ? '1 : parityOf(memAddr);
    end
  end

  // ==========================================================
  // wishbone register slave
  logic          busReq;
  logic [ST_W-1:0] status;

  assign busReq = cyc_i && stb_i && !ack_o;
  assign status[ST_PEND_LSB +: DEPTH] = pendAny;
  assign status[ST_LW_LSB +: PTR_W]   = lastWritten_reg;
  assign status[ST_LW_VALID]          = lwValid_reg;
  assign status[ST_BUSY]              = busy_reg;
  assign status[ST_DRAIN]             = drainMode;
  assign status[ST_FULL]              = bufferFull;
  assign status[ST_CHAIN]             = chainActive;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_o    <= 1'b0;
      dat_o    <= '0;
      diag_reg <= DIAG_RESET;
    end else if (clockEnable) begin
      ack_o <= busReq;
      // write lands on the edge at which the master sees ack
      if (cyc_i && stb_i && ack_o && we_i && sel_i[0] &&
          regSel(adr_i, REG_DIAG)) begin
        diag_reg <= dat_i[DIAG_W-1:0];
      end
      if (busReq) begin
        if (regSel(adr_i, REG_DIAG)) begin
          dat_o <= 32'(diag_reg);
        end else if (regSel(adr_i, REG_STATUS)) begin
          dat_o <= 32'(status);
        end else begin
          dat_o <= '0;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !clockEnable);

  sequence s_chainTail;
    beat1_reg ##1 beat2_reg ##1 beat3_reg;
  endsequence

  sequence s_busyWindow;
    !memBusyN ##1 memBusyN;
  endsequence

  a_chain_beats: assert property (write_ack_chain_reg |=> s_chainTail)
    else $error("write-ack beats out of order");
  a_busy_release: assert property (write_ack_chain_reg |=> s_busyWindow)
    else $error("busy not released at third beat");
  a_avail_gate: assert property (!preWriteAckN |-> mtIdle && !chainActive)
    else $error("chain started while buffer unavailable");
  a_capture_write: assert property (captureWrite |=>
    writeReq_reg && !memBusyN && inAddr_reg == $past(cpuAddr))
    else $error("write capture missing");
  a_read_start: assert property (captureRead |=>
    readReq_reg && !memBusyN)
    else $error("read capture missing");
  a_hit_pointer: assert property (!preWriteAckN && hitNow &&
    !diag_reg[DIAG_FORCE_EN] |=> wbPtr_reg == $past(hitPtr))
    else $error("hit pointer not chosen");
  a_sched_frozen: assert property (chainActive |=>
    $stable(mtWriteReq) && $stable(mtReadReq) && $stable(reqPointer))
    else $error("scheduler outputs moved during chain");
  a_lw_update: assert property (beat2_reg |=>
    lastWritten_reg == $past(wbPtr_reg) && lwValid_reg)
    else $error("last-written latch not updated");
  a_abort_end: assert property (beat3_reg |=> !writeAbort)
    else $error("abort not ended after fourth beat");
  a_flags_gated: assert property (!mtWriteReq |-> !mtWrite64 && !mtWriteOdd)
    else $error("write flags without write request");
  a_single_full: assert property (diag_reg[DIAG_SINGLE] && (|pendAny)
    |-> bufferFull)
    else $error("single-op full not reported");
  a_drain_all: assert property (diag_reg[DIAG_DRAIN] && nPend != 3'd0 &&
    !schedHold |=> mtWriteReq || mtReadReq)
    else $error("drain-all did not request");
  a_auto_drain: assert property (stuckZero |=> autoDrain_reg)
    else $error("stuck location 0 not drained");
  a_no_lw_pick: assert property (mtWriteReq && !$past(drainMode) &&
    !$past(lwDis) && $past(lwValid_reg) && !$past(schedHold)
    |-> reqPointer != $past(lastWritten_reg))
    else $error("last-written location requested");
  a_parity_forced: assert property (diag_reg[DIAG_BADPAR] |=>
    &memAddrParity)
    else $error("parity not forced high");

endmodule : write_buffer_scheduler_ack

// File: sim/mem_timer_model.sv
// memory timer stand-in serving scheduler requests after random delays
`timescale 1ns/1ps
module mem_timer_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       mtWriteReq,
  input  wire logic       mtReadReq,
  input  wire logic [1:0] reqPointer,
  output logic            mtIdle,
  output logic            mtWriteDone,
  output logic            mtFillDone,
  output logic [1:0]      mtDonePtr
);
  int   cnt;
  logic isWrite;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {cnt, isWrite, mtWriteDone, mtFillDone, mtDonePtr} <= '0;
      mtIdle <= 1'b1;
    end else if (cnt == 0) begin
      {mtWriteDone, mtFillDone, mtIdle} <= 3'b001;
      // pointer not meaningful when idle
      mtDonePtr <= ~mtDonePtr;
      if (mtWriteReq || mtReadReq) begin
        cnt <= 3 + $urandom % 8;
        isWrite <= mtWriteReq;
        mtDonePtr <= reqPointer;
        mtIdle <= 1'b0;
      end
    end else begin
      cnt <= cnt - 1;
      // done two cycles early: stale request latch reloads before next take
      {mtWriteDone, mtFillDone} <= (cnt == 3) ? {isWrite, !isWrite} : 2'b00;
      if (cnt == 3) begin
        mtIdle <= 1'b1;
      end
    end
  end
endmodule : mem_timer_model

// File: sim/write_buffer_scheduler_ack_tb.sv
// self-checking bench for the write buffer scheduler and ack chain
`timescale 1ns/1ps
module write_buffer_scheduler_ack_tb;
  import write_buffer_pkg::*;
  logic clock, clockEnable, nrst, cyc_i, stb_i, we_i, ack_o, stepCaptureEdge;
  logic memWriteDest, memWrite32Dest, cacheMiss, fastRead64Cmd, memBusyN;
  logic cpuReadReq, cpuReadDone, mtIdle, mtWriteReq, mtReadReq, mtWrite64;
  logic mtWriteOdd, mtWriteDone, mtFillDone, writeAbort, bufferFull;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, cpuData, rd, d1;
  logic [25:0] cpuAddr;
  logic [23:0] memAddr, t1;
  logic [1:0]  reqPointer, mtDonePtr;
  logic [2:0]  memAddrParity;
  logic [63:0] memData;
  int          fail_count = 0, n_tests = 0, n;
  write_buffer_scheduler_ack u_dut (
    .clock, .clockEnable, .nrst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .stepCaptureEdge, .memWriteDest,
    .memWrite32Dest, .cacheMiss, .fastRead64Cmd, .cpuAddr, .cpuData,
    .memBusyN, .cpuReadReq, .cpuReadDone, .mtIdle, .mtWriteReq,
    .mtReadReq, .mtWrite64, .mtWriteOdd, .reqPointer, .mtWriteDone,
    .mtFillDone, .mtDonePtr, .memAddr, .memAddrParity, .memData,
    .writeAbort, .bufferFull
  );
  mem_timer_model u_mt (
    .clock, .nrst, .mtWriteReq, .mtReadReq, .reqPointer, .mtIdle,
    .mtWriteDone, .mtFillDone, .mtDonePtr
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20) fail_count++;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic cw(input logic [25:0] a);
    @(posedge clock);
    while (memBusyN !== 1'b1) @(posedge clock);
    {stepCaptureEdge, memWrite32Dest, cpuAddr} <= {2'b11, a};
    cpuData <= $urandom;
    @(posedge clock);
    {stepCaptureEdge, memWrite32Dest} <= 2'b00;
    n = 0;
    #1;
    while (memBusyN === 1'b0 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : cw
  task automatic st(input logic [3:0] e);
    repeat (60) @(posedge clock);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'hf, {28'h0, e});
  endtask : st
  // ==========================================================
  // main sequence
  initial begin
    {clockEnable, nrst, cyc_i, stb_i, we_i, stepCaptureEdge} = 6'b100000;
    {memWriteDest, memWrite32Dest, cacheMiss, fastRead64Cmd} = 4'h0;
    {cpuReadDone, adr_i, sel_i, dat_i, cpuData, cpuAddr} = {9'h0f, 90'h0};
    n = $urandom(32'ha0cac2a1);
    t1 = $urandom;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    wb(1'b1, REG_DIAG, 32'h0);
    wb(1'b0, REG_DIAG, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    cw({t1, 2'b00});
    d1 = cpuData;
    chk(n, 3);
    chk({31'h0, writeAbort}, 32'h1);
    st(4'h8);
    cw({~t1, 2'b00});
    while (mtWriteReq !== 1'b1) @(posedge clock);
    chk({mtWrite64, mtWriteOdd, reqPointer}, 32'h3);
    chk({8'h0, memAddr}, {8'h0, t1});
    chk(memData[31:0], d1);
    st(4'h4);
    cw({~t1, 2'b10});
    chk(n, 3);
    st(4'h4);
    chk({31'h0, bufferFull}, 32'h0);
    wb(1'b1, REG_DIAG, 32'h1);
    @(posedge clock);
    chk({31'h0, bufferFull}, 32'h1);
    wb(1'b1, REG_DIAG, 32'h2);
    while (mtWriteReq !== 1'b1) @(posedge clock);
    chk({mtWrite64, mtWriteOdd, reqPointer}, 32'ha);
    st(4'h0);
    wb(1'b1, REG_DIAG, 32'h8);
    repeat (2) @(posedge clock);
    chk({29'h0, memAddrParity}, 32'h7);
    wb(1'b1, REG_DIAG, 32'h0);
    {stepCaptureEdge, fastRead64Cmd} <= 2'b11;
    @(posedge clock);
    {stepCaptureEdge, fastRead64Cmd} <= 2'b00;
    n = 0;
    while (cpuReadReq !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, memBusyN}, 32'h0);
    cpuReadDone <= 1'b1;
    @(posedge clock);
    cpuReadDone <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, memBusyN}, 32'h1);
    // a capture while the clock enable is low must be ignored
    {clockEnable, stepCaptureEdge, cacheMiss} <= 3'b011;
    repeat (3) @(posedge clock);
    {clockEnable, stepCaptureEdge, cacheMiss} <= 3'b100;
    repeat (2) @(posedge clock);
    chk({31'h0, memBusyN}, 32'h1);
    stop_test();
  end
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule : write_buffer_scheduler_ack_tb
